// ---- design/fwc_flash_write_controller.sv ----
// Flash write controller: word programming, page wipe, DMA pacing
// Notes on behaviour
// - Flash holds 8/16/32 pages of 1024 bytes.
// - Erase by page, program by 16-bit word.
// - Programming uses 14-bit word address from registers.
// - Wipe page chosen by high address bits 5:1.
// - Word in page is high bit0 plus low.
// - Program-go streams any number of sequential words.
// - Programming only clears bits, never sets them.
// - Word-program-active high during each word write.
// - First byte is LSB, second is MSB.
// - Second byte starts word write; supplier sends pairs.
// - CPU flash access stalled while programming.
// - Access while word active flags a violation.
// - DMA trigger whenever data port is ready for the next byte.
// - Program-go with armed DMA triggers immediately.
// - Both bytes within 40 us, else abort.
// - Abort leaves failing address; go again resumes.
// - CPU continues after go when running from RAM.
// - Wipe 20 ms, chip 200 ms, word 20 us.
// - Flash powers down between slow-clock reads.
// - Page wipe leaves the page all ones.
// - Wipe with go completes wipe before programming.
// - Op-active flag high during program or wipe.
`timescale 1ns/1ps
module fwc_flash_write_controller #(
  parameter int unsigned TIMEOUT_CYC = fwc_pkg::TIMEOUT_CYC,
  parameter int unsigned WORD_PROG_CYC = fwc_pkg::WORD_PROG_CYC,
  parameter int unsigned PAGE_WIPE_CYC = fwc_pkg::PAGE_WIPE_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic go_set_i,
  input wire logic wipe_set_i,
  input wire logic stop_i,
  input wire logic addr_high_we_i,
  input wire logic addr_low_we_i,
  input wire logic [7:0] addr_wdata_i,
  input wire logic data_we_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic dma_armed_i,
  input wire logic [4:0] dma_event_select_i,
  input wire logic cpu_flash_req_i,
  input wire logic cpu_from_ram_i,
  input wire logic [2:0] cpu_clock_divider_i,
  input wire logic [15:0] flash_rdata_i,
  output logic program_go_o,
  output logic page_wipe_go_o,
  output logic word_program_active_o,
  output logic nvm_op_active_o,
  output logic [7:0] word_addr_high_o,
  output logic [7:0] word_addr_low_o,
  output logic [7:0] program_data_port_o,
  output logic dma_req_o,
  output logic cpu_stall_o,
  output logic access_violation_o,
  output logic flash_pwr_down_o,
  output fwc_pkg::fwc_prog_s prog_o,
  output fwc_pkg::fwc_wipe_s wipe_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  fwc_pkg::fwc_state_e state_ff, nxt_state;
  logic go_ff, nxt_go;
  logic wipe_ff, nxt_wipe;
  logic swb_ff, nxt_swb;
  logic half_ff, nxt_half;
  logic [7:0] lsb_ff, nxt_lsb;
  logic [7:0] ah_ff, nxt_ah;
  logic [7:0] al_ff, nxt_al;
  logic [7:0] dat_ff, nxt_dat;
  logic [fwc_pkg::CNT_BITS-1:0] cnt_ff, nxt_cnt;
  logic dma_ff, nxt_dma;
  logic stall_ff, nxt_stall;
  logic viol_ff, nxt_viol;
  logic pd_ff, nxt_pd;
  logic busy_ff, nxt_busy;
  fwc_pkg::fwc_prog_s prog_ff, nxt_prog;
  fwc_pkg::fwc_wipe_s wp_ff, nxt_wp;
  logic [13:0] waddr;
  logic dma_sel;

  function automatic logic [13:0] addr_join(input logic [7:0] h,
                                            input logic [7:0] l);
    addr_join = {h[5:0], l};
  endfunction

  assign waddr = addr_join(ah_ff, al_ff);
  assign dma_sel = dma_armed_i
    && (dma_event_select_i == fwc_pkg::DMA_DMA_EVENT_SELECT_FLASH);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_go = go_ff;
    nxt_wipe = wipe_ff;
    nxt_swb = swb_ff;
    nxt_half = half_ff;
    nxt_lsb = lsb_ff;
    nxt_ah = ah_ff;
    nxt_al = al_ff;
    nxt_dat = dat_ff;
    nxt_cnt = cnt_ff;
    nxt_prog = prog_ff;
    nxt_prog.wr = 1'b0;
    nxt_wp = wp_ff;
    nxt_wp.wipe = 1'b0;
    nxt_dma = 1'b0;
    if (addr_high_we_i && state_ff == fwc_pkg::ST_IDLE)
    begin
      nxt_ah = addr_wdata_i;
    end
    if (addr_low_we_i && state_ff == fwc_pkg::ST_IDLE)
    begin
      nxt_al = addr_wdata_i;
    end
    if (data_we_i)
    begin
      nxt_dat = data_wdata_i;
    end
    case (state_ff)
      fwc_pkg::ST_IDLE:
      begin
        nxt_half = 1'b0;
        nxt_cnt = '0;
        if (wipe_set_i)
        begin
          // Wipe first even when go arrives in the same write
          nxt_wipe = 1'b1;
          nxt_go = go_set_i;
          nxt_wp.wipe = 1'b1;
          nxt_wp.page = ah_ff[5:1];
          nxt_state = fwc_pkg::ST_WIPE;
        end
        else if (go_set_i)
        begin
          nxt_go = 1'b1;
          nxt_dma = dma_sel;
          nxt_state = fwc_pkg::ST_WAIT;
        end
      end
      fwc_pkg::ST_WIPE:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff >= PAGE_WIPE_CYC - 1)
        begin
          nxt_wipe = 1'b0;
          nxt_cnt = '0;
          nxt_dma = go_ff && dma_sel;
          nxt_state = go_ff ? fwc_pkg::ST_WAIT : fwc_pkg::ST_IDLE;
        end
      end
      fwc_pkg::ST_WAIT:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        if (data_we_i && !half_ff)
        begin
          nxt_lsb = data_wdata_i;
          nxt_half = 1'b1;
          nxt_dma = dma_sel;
        end
        else if (data_we_i)
        begin
          // Programming can only pull ones to zero
          nxt_prog.wr = 1'b1;
          nxt_prog.addr = waddr;
          nxt_prog.data = {data_wdata_i, lsb_ff} & flash_rdata_i;
          nxt_half = 1'b0;
          nxt_swb = 1'b1;
          nxt_cnt = '0;
          nxt_state = fwc_pkg::ST_PROG;
        end
        else if (stop_i || cnt_ff >= TIMEOUT_CYC - 1)
        begin
          // Abort keeps the failing word address for a resume
          nxt_go = 1'b0;
          nxt_half = 1'b0;
          nxt_state = fwc_pkg::ST_IDLE;
        end
      end
      fwc_pkg::ST_PROG:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff >= WORD_PROG_CYC - 1)
        begin
          nxt_swb = 1'b0;
          nxt_cnt = '0;
          {nxt_ah[5:0], nxt_al} = waddr + 14'h0001;
          nxt_dma = dma_sel;
          nxt_state = fwc_pkg::ST_WAIT;
        end
      end
      default:
      begin
        nxt_state = fwc_pkg::ST_IDLE;
      end
    endcase
    // Registered from the next state so the flag leaves a flop
    nxt_busy = (nxt_state != fwc_pkg::ST_IDLE);
  end

  // ----------------------------------------------------------------------
  // CPU side: stall, violation, power down
  // ----------------------------------------------------------------------
  always_comb
  begin
    // RAM code keeps running; flash fetches wait out the operation
    nxt_stall = cpu_flash_req_i && !cpu_from_ram_i
      && (nxt_state != fwc_pkg::ST_IDLE);
    nxt_viol = cpu_flash_req_i && swb_ff;
    nxt_pd = (cpu_clock_divider_i != 3'h0) && !cpu_flash_req_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= fwc_pkg::ST_IDLE;
      go_ff <= 1'b0;
      wipe_ff <= 1'b0;
      swb_ff <= 1'b0;
      half_ff <= 1'b0;
      lsb_ff <= 8'h00;
      ah_ff <= fwc_pkg::ADDR_HIGH_RST;
      al_ff <= fwc_pkg::ADDR_LOW_RST;
      dat_ff <= fwc_pkg::DATA_RST;
      cnt_ff <= '0;
      dma_ff <= 1'b0;
      stall_ff <= 1'b0;
      viol_ff <= 1'b0;
      pd_ff <= 1'b0;
      busy_ff <= 1'b0;
      prog_ff <= '0;
      wp_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      go_ff <= nxt_go;
      wipe_ff <= nxt_wipe;
      swb_ff <= nxt_swb;
      half_ff <= nxt_half;
      lsb_ff <= nxt_lsb;
      ah_ff <= nxt_ah;
      al_ff <= nxt_al;
      dat_ff <= nxt_dat;
      cnt_ff <= nxt_cnt;
      dma_ff <= nxt_dma;
      stall_ff <= nxt_stall;
      viol_ff <= nxt_viol;
      pd_ff <= nxt_pd;
      busy_ff <= nxt_busy;
      prog_ff <= nxt_prog;
      wp_ff <= nxt_wp;
    end
  end

  assign program_go_o = go_ff;
  assign page_wipe_go_o = wipe_ff;
  assign word_program_active_o = swb_ff;
  assign nvm_op_active_o = busy_ff;
  assign word_addr_high_o = {2'b00, ah_ff[5:0]};
  assign word_addr_low_o = al_ff;
  assign program_data_port_o = dat_ff;
  assign dma_req_o = dma_ff;
  assign cpu_stall_o = stall_ff;
  assign access_violation_o = viol_ff;
  assign flash_pwr_down_o = pd_ff;
  assign prog_o = prog_ff;
  assign wipe_o = wp_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_second_byte;
    state_ff == fwc_pkg::ST_WAIT && data_we_i && half_ff;
  endsequence

  AST_WORD_START: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_second_byte |=> prog_o.wr && word_program_active_o)
    else $error("second byte did not start a word write");
  AST_LSB_FIRST: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_second_byte |=> prog_o.data[15:8] == ($past(data_wdata_i)
      & $past(flash_rdata_i[15:8])))
    else $error("byte order wrong");
  AST_ONLY_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_second_byte |=> (prog_o.data & ~$past(flash_rdata_i)) == 16'h0000)
    else $error("program raised a bit");
  AST_BUSY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (word_program_active_o || page_wipe_go_o) |-> nvm_op_active_o)
    else $error("busy low during operation");
  AST_GO_DMA: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_ff == fwc_pkg::ST_IDLE && go_set_i && !wipe_set_i && dma_sel)
      |=> dma_req_o && program_go_o)
    else $error("no first dma trigger");
  AST_ADVANCE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ($fell(word_program_active_o)) |-> waddr == $past(waddr) + 14'h0001)
    else $error("address did not advance");
  AST_WIPE_FIRST: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_ff == fwc_pkg::ST_IDLE && wipe_set_i) |=> page_wipe_go_o
      && state_ff == fwc_pkg::ST_WIPE)
    else $error("wipe not first");
  AST_VIOL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cpu_flash_req_i && word_program_active_o) |=> access_violation_o)
    else $error("violation missed");
  AST_ABORT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_ff == fwc_pkg::ST_WAIT && !data_we_i && !stop_i
      && cnt_ff >= TIMEOUT_CYC - 1) |=> !program_go_o && !nvm_op_active_o
      && $stable(waddr))
    else $error("timeout abort wrong");

endmodule // fwc_flash_write_controller

// ---- design/fwc_pkg.sv ----
// Package of constants and types for the flash write controller
package fwc_pkg;

  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned PAGE_BYTES = 1024;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned ADDR_BITS = 14;
  localparam int unsigned PAGE_WORDS = 512;
  localparam logic [4:0] DMA_DMA_EVENT_SELECT_FLASH = 5'h12;
  localparam logic [7:0] ADDR_HIGH_RST = 8'h00;
  localparam logic [7:0] ADDR_LOW_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Times in microseconds or milliseconds as printed, cycle counts derived from the clock
  localparam int unsigned TIMEOUT_US = 40;
  localparam int unsigned WORD_PROG_US = 20;
  localparam int unsigned PAGE_WIPE_MS = 20;
  localparam int unsigned CHIP_WIPE_MS = 200;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int unsigned WORD_PROG_CYC = WORD_PROG_US * CLK_MHZ;
  localparam int unsigned PAGE_WIPE_CYC = PAGE_WIPE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CHIP_WIPE_CYC = CHIP_WIPE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_BITS = 32;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WIPE = 4'h2,
    ST_WAIT = 4'h4,
    ST_PROG = 4'h8
  } fwc_state_e;

  // Array write command towards the flash macro
  typedef struct packed {
    logic wr;
    logic [ADDR_BITS-1:0] addr;
    logic [WORD_BITS-1:0] data;
  } fwc_prog_s;

  typedef struct packed {
    logic wipe;
    logic [4:0] page;
  } fwc_wipe_s;

endpackage

// ---- tb/fwc_flash_model.sv ----
// Behavioural flash array standing behind the write controller
`timescale 1ns/1ps
module fwc_flash_model (
  input wire logic core_clk_i,
  input wire logic [13:0] addr_i,
  input wire fwc_pkg::fwc_prog_s prog_i,
  input wire fwc_pkg::fwc_wipe_s wipe_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [0:16383];

  initial
  begin
    for (int i = 0; i < 16384; i++)
      mem[i] = 16'hffff;
  end

  // Contents of the word the controller currently targets
  assign rdata_o = mem[addr_i];

  always @(posedge core_clk_i)
  begin
    // Cells only discharge, so a one can never restore a zero
    if (prog_i.wr === 1'b1)
      mem[prog_i.addr] <= mem[prog_i.addr] & prog_i.data;
    if (wipe_i.wipe === 1'b1)
      for (int i = 0; i < 512; i++)
        mem[{wipe_i.page, 9'h000} + 14'(i)] <= 16'hffff;
  end
endmodule // fwc_flash_model

// ---- tb/testbench.sv ----
// Self-checking testbench for the flash write controller
`timescale 1ns/1ps
module testbench;
  // Shortened counts keep the run brief; expectations follow them
  localparam int TO_CYC = 50;
  localparam int WP_CYC = 20;
  localparam int PW_CYC = 30;
  logic core_clk_i, rst_n_i, go_set_i, wipe_set_i, stop_i;
  logic addr_high_we_i, addr_low_we_i, data_we_i, dma_armed_i;
  logic cpu_flash_req_i, cpu_from_ram_i;
  logic [7:0] addr_wdata_i, data_wdata_i;
  logic [4:0] dma_event_select_i;
  logic [2:0] cpu_clock_divider_i;
  logic [15:0] flash_rdata_i;
  logic program_go_o, page_wipe_go_o, word_program_active_o;
  logic nvm_op_active_o, dma_req_o, cpu_stall_o;
  logic access_violation_o, flash_pwr_down_o;
  logic [7:0] word_addr_high_o, word_addr_low_o, program_data_port_o;
  fwc_pkg::fwc_prog_s prog_o, last_prog;
  fwc_pkg::fwc_wipe_s wipe_o, last_wipe;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int wr_cnt = 0;
  int dma_cnt = 0;
  int wipe_cnt = 0;

  fwc_flash_write_controller #(.TIMEOUT_CYC(TO_CYC), .WORD_PROG_CYC(WP_CYC),
    .PAGE_WIPE_CYC(PW_CYC)) dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .go_set_i(go_set_i), .wipe_set_i(wipe_set_i), .stop_i(stop_i),
    .addr_high_we_i(addr_high_we_i), .addr_low_we_i(addr_low_we_i),
    .addr_wdata_i(addr_wdata_i), .data_we_i(data_we_i),
    .data_wdata_i(data_wdata_i), .dma_armed_i(dma_armed_i),
    .dma_event_select_i(dma_event_select_i),
    .cpu_flash_req_i(cpu_flash_req_i), .cpu_from_ram_i(cpu_from_ram_i),
    .cpu_clock_divider_i(cpu_clock_divider_i),
    .flash_rdata_i(flash_rdata_i), .program_go_o(program_go_o),
    .page_wipe_go_o(page_wipe_go_o),
    .word_program_active_o(word_program_active_o),
    .nvm_op_active_o(nvm_op_active_o), .word_addr_high_o(word_addr_high_o),
    .word_addr_low_o(word_addr_low_o),
    .program_data_port_o(program_data_port_o),
    .dma_req_o(dma_req_o), .cpu_stall_o(cpu_stall_o),
    .access_violation_o(access_violation_o),
    .flash_pwr_down_o(flash_pwr_down_o), .prog_o(prog_o),
    .wipe_o(wipe_o));

  fwc_flash_model far (.core_clk_i(core_clk_i),
    .addr_i({word_addr_high_o[5:0], word_addr_low_o}), .prog_i(prog_o),
    .wipe_i(wipe_o), .rdata_o(flash_rdata_i));

  // ---------------------------------------------------------------
  // Clock, pulse capture and hang guard
  // ---------------------------------------------------------------
  always #2 core_clk_i = ~core_clk_i;

  // Pulses last one cycle, so they are latched rather than sampled late
  always @(posedge core_clk_i)
  begin
    cycles <= cycles + 1;
    if (prog_o.wr === 1'b1)
    begin
      wr_cnt++;
      last_prog = prog_o;
    end
    if (dma_req_o === 1'b1)
      dma_cnt++;
    if (wipe_o.wipe === 1'b1)
    begin
      wipe_cnt++;
      last_wipe = wipe_o;
    end
    if (cycles == 2000)
    begin
      errors++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
    @(posedge core_clk_i);
    addr_high_we_i <= 1'b1;
    addr_wdata_i <= hi;
    @(posedge core_clk_i);
    addr_high_we_i <= 1'b0;
    addr_low_we_i <= 1'b1;
    addr_wdata_i <= lo;
    @(posedge core_clk_i);
    addr_low_we_i <= 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b);
    @(posedge core_clk_i);
    data_we_i <= 1'b1;
    data_wdata_i <= b;
    @(posedge core_clk_i);
    data_we_i <= 1'b0;
  endtask

  task automatic start(input logic wipe);
    @(posedge core_clk_i);
    // One clean go strobe, as from an aligned trigger instruction
    go_set_i <= 1'b1;
    wipe_set_i <= wipe;
    @(posedge core_clk_i);
    go_set_i <= 1'b0;
    wipe_set_i <= 1'b0;
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_word(input string name, input logic [15:0] exp,
                          input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    rst_n_i = 1'b0;
    {go_set_i, wipe_set_i, stop_i, addr_high_we_i, addr_low_we_i} = 5'h00;
    {data_we_i, cpu_from_ram_i, addr_wdata_i, data_wdata_i} = 18'h00000;
    dma_armed_i = 1'b1;
    dma_event_select_i = fwc_pkg::DMA_DMA_EVENT_SELECT_FLASH;
    cpu_flash_req_i = 1'b1;
    cpu_clock_divider_i = 3'h0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    wait_cyc(1);
    chk_bit("op_active", 1'b0, nvm_op_active_o);
    chk_bit("program_go", 1'b0, program_go_o);
    chk_bit("stall_idle", 1'b0, cpu_stall_o);
    chk_bit("violation_idle", 1'b0, access_violation_o);
    chk_bit("power_down_fast", 1'b0, flash_pwr_down_o);
    $display("Test reset done");
    set_addr(8'h05, 8'hff);
    start(1'b0);
    wait_cyc(2);
    chk_bit("program_go", 1'b1, program_go_o);
    chk_bit("op_active", 1'b1, nvm_op_active_o);
    chk_word("dma_first", 16'h0001, 16'(dma_cnt));
    put_byte(8'h34);
    put_byte(8'h12);
    wait_cyc(2);
    chk_word("dma_after_lsb", 16'h0002, 16'(dma_cnt));
    chk_bit("word_active", 1'b1, word_program_active_o);
    chk_bit("stall_busy", 1'b1, cpu_stall_o);
    chk_bit("violation", 1'b1, access_violation_o);
    chk_word("data_port", 16'h0012, {8'h00, program_data_port_o});
    chk_word("prog_data", 16'h1234, last_prog.data);
    chk_word("prog_addr", 16'h05ff, {2'b00, last_prog.addr});
    // Code running from RAM must not be held while the word programs
    @(posedge core_clk_i);
    cpu_from_ram_i <= 1'b1;
    wait_cyc(2);
    chk_bit("stall_from_ram", 1'b0, cpu_stall_o);
    @(posedge core_clk_i);
    cpu_from_ram_i <= 1'b0;
    wait_cyc(WP_CYC + 2);
    chk_bit("word_active", 1'b0, word_program_active_o);
    chk_bit("violation_clear", 1'b0, access_violation_o);
    chk_word("addr_next", 16'h0600,
             {word_addr_high_o, word_addr_low_o});
    chk_word("dma_next", 16'h0003, 16'(dma_cnt));
    $display("Test word write done");
    wait_cyc(TO_CYC + 5);
    chk_bit("program_go", 1'b0, program_go_o);
    chk_bit("op_active", 1'b0, nvm_op_active_o);
    chk_word("addr_kept", 16'h0600,
             {word_addr_high_o, word_addr_low_o});
    $display("Test timeout done");
    // Another trigger source selected: no pacing pulses expected
    @(posedge core_clk_i);
    dma_event_select_i <= 5'h11;
    set_addr(8'h05, 8'hff);
    start(1'b0);
    put_byte(8'hf0);
    put_byte(8'h0f);
    wait_cyc(2);
    chk_word("and_data", 16'h0230, last_prog.data);
    chk_word("word_count", 16'h0002, 16'(wr_cnt));
    chk_word("dma_unselected", 16'h0003, 16'(dma_cnt));
    wait_cyc(WP_CYC + 2);
    @(posedge core_clk_i);
    stop_i <= 1'b1;
    @(posedge core_clk_i);
    stop_i <= 1'b0;
    wait_cyc(2);
    chk_bit("program_go", 1'b0, program_go_o);
    $display("Test rewrite done");
    @(posedge core_clk_i);
    dma_event_select_i <= fwc_pkg::DMA_DMA_EVENT_SELECT_FLASH;
    set_addr(8'h05, 8'hff);
    start(1'b1);
    wait_cyc(2);
    chk_bit("op_active", 1'b1, nvm_op_active_o);
    wait_cyc(PW_CYC + 4);
    chk_word("wipe_count", 16'h0001, 16'(wipe_cnt));
    chk_word("wipe_page", 16'h0002, {11'h000, last_wipe.page});
    chk_bit("program_go", 1'b1, program_go_o);
    chk_word("dma_after_wipe", 16'h0004, 16'(dma_cnt));
    put_byte(8'h34);
    put_byte(8'h12);
    wait_cyc(2);
    chk_word("data_after_wipe", 16'h1234, last_prog.data);
    $display("Test wipe done");
    // Divided clock and no read pending lets the array sleep
    @(posedge core_clk_i);
    cpu_clock_divider_i <= 3'h3;
    cpu_flash_req_i <= 1'b0;
    wait_cyc(2);
    chk_bit("power_down_slow", 1'b1, flash_pwr_down_o);
    @(posedge core_clk_i);
    cpu_flash_req_i <= 1'b1;
    wait_cyc(2);
    chk_bit("power_up_read", 1'b0, flash_pwr_down_o);
    $display("Test power down done");
    finish_test();
  end
endmodule // testbench
